/* File: include/lsd_regs.vh */
// Constants for the lane sleep, initialization and deskew controller
`ifndef LSD_REGS_VH
`define LSD_REGS_VH
// Low-power line states {P,N}
`define LSD_LP00 2'h0
`define LSD_LP01 2'h1
`define LSD_LP10 2'h2
`define LSD_LP11 2'h3
// Timing in ns and derived cycle counts at 40 MHz
`define LSD_CLK_NS 25
`define LSD_INIT_MIN_NS 100000
`define LSD_INIT_MIN_CYC ((`LSD_INIT_MIN_NS + `LSD_CLK_NS - 1) / `LSD_CLK_NS)
`define LSD_CAL_INIT_NS 100000
`define LSD_CAL_PER_NS 10000
`define LSD_CAL_INIT_CYC (`LSD_CAL_INIT_NS / `LSD_CLK_NS)
`define LSD_CAL_PER_CYC (`LSD_CAL_PER_NS / `LSD_CLK_NS)
// Deskew burst lengths in UI
`define LSD_SYNC_UI 16
`define LSD_INIT_PAY_UI 32768
`define LSD_PER_PAY_UI 1024
`endif

/* File: hdl/lsd_sync.v */
// Two flip-flop synchroniser
`timescale 1ns/1ps
module lsd_sync #(
  parameter W = 1
) (
  input wire CLK_SYS,
  input wire RST_N,
  input wire [W-1:0] D,
  output reg [W-1:0] Q
);
  reg [W-1:0] meta;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      meta <= {W{1'b0}};
      Q <= {W{1'b0}};
    end else begin
      meta <= D;
      Q <= meta;
    end
  end
endmodule // lsd_sync

/* File: hdl/lsd_dcnt.v */
// Loadable down-counter
`timescale 1ns/1ps
module lsd_dcnt #(
  parameter W = 24
) (
  input wire CLK_SYS,
  input wire RST_N,
  input wire load,
  input wire [W-1:0] value,
  input wire run,
  output wire zero
);
  reg [W-1:0] cnt;
  assign zero = (cnt == {W{1'b0}});
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cnt <= {W{1'b0}};
    end else if (load) begin
      cnt <= value;
    end else if (run && !zero) begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // lsd_dcnt

/* File: hdl/lsd_lane_ctrl.v */
// Lane sleep, initialization and deskew controller
// Notes on behaviour
// - Clock lane supports sleep without escape mode
// - Sleep entry: stop, request, then all-low
// - Receiver aborts entry on 01 or 11
// - Receiver flags sleep state to protocol
// - Wake mark for hold time, then stop
// - Each side meets its own timing intervals
// - Receiver accepts any conformant transmitter timing
// - Clock absence reinitializes test pattern checkers
// - Lane manages its own power mode changes
// - Slave initialized after stop longer than interval
// - Master initialized by protocol request
// - Slave ignores lines before initialization period
// - All lanes complete initialization together
// - Init lengths programmable, at least 100 us
// - Initial deskew required above threshold rate
// - Initial deskew optional below, periodic optional
// - Deskew may be skipped on resumed rate
// - Burst starts with sixteen UI of ones
// - Alternating payload, 2^15 or 2^10 UI
// - Receiver starts calibration on sync detect
// - Deskew starts on all lanes together
// - Periodic deskew waits for current burst end
// - Receiver calibrates within 100 or 10 us; the slave always loads CAL_INIT_CYC, as only master bursts set deskewed
`timescale 1ns/1ps
`include "lsd_regs.vh"
module lsd_lane_ctrl #(
  parameter LANES = 2,
  parameter CW = 24,
  parameter UW = 16,
  parameter [CW-1:0] CAL_INIT_CYC = `LSD_CAL_INIT_CYC,
  parameter [CW-1:0] CAL_PER_CYC = `LSD_CAL_PER_CYC
) (
  input wire CLK_SYS,
  input wire RST_N,
  input wire IS_MASTER,
  input wire INIT_REQ,
  input wire [CW-1:0] INIT_CYC,
  input wire [CW-1:0] WAKE_CYC,
  output reg INIT_DONE,
  input wire SLEEP_REQ,
  input wire WAKE_REQ,
  output reg TX_LP_OE,
  output reg [1:0] TX_LP,
  input wire [1:0] RX_LP,
  output reg RX_SLEEP,
  output reg RX_ABORT,
  output reg LOW_POWER,
  input wire HS_BYTE_CLK,
  input wire TEST_MODE,
  input wire [CW-1:0] MISS_CYC,
  output reg CHECK_REINIT,
  input wire HIGH_RATE,
  input wire RATE_CHANGED,
  input wire DESKEW_REQ,
  input wire DESKEW_PERIODIC,
  input wire HS_BURST_ACTIVE,
  output wire DESKEW_BUSY,
  output reg [LANES-1:0] HS_SERIAL,
  output reg HS_EN,
  input wire [LANES-1:0] RX_HS,
  output reg RX_CAL_ACTIVE,
  output reg RX_CAL_TIMEOUT
);
  // ****************************************
  // Input synchronisation
  // ****************************************
  // High-speed bits share the clock's latency so each is seen as it stood at its edge
  wire [1:0] rx_lp;
  wire hs_clk_s;
  wire [LANES-1:0] rx_hs;
  lsd_sync #(.W(3 + LANES)) u_sync (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .D({RX_LP, HS_BYTE_CLK, RX_HS}),
    .Q({rx_lp, hs_clk_s, rx_hs})
  );
  reg hs_clk_d;
  always @(posedge CLK_SYS) begin
    if (!RST_N) hs_clk_d <= 1'b0;
    else hs_clk_d <= hs_clk_s;
  end
  wire hs_edge = hs_clk_s ^ hs_clk_d;
  // ****************************************
  // Shared interval counter
  // ****************************************
  localparam S_IDLE = 4'h0;
  localparam S_INIT = 4'h1;
  localparam S_STOP = 4'h2;
  localparam S_REQ = 4'h3;
  localparam S_SLEEP = 4'h4;
  localparam S_WAKE = 4'h5;
  localparam S_RXWAIT = 4'h6;
  localparam S_SYNC = 4'h7;
  localparam S_PAY = 4'h8;
  reg [3:0] state;
  reg [3:0] next_state;
  reg tmr_load;
  reg [CW-1:0] tmr_val;
  wire tmr_zero;
  localparam [CW-1:0] INIT_MIN = `LSD_INIT_MIN_CYC;
  // Clamp programmed init length to the floor
  function [CW-1:0] clamp_init;
    input [CW-1:0] v;
    begin
      clamp_init = (v < INIT_MIN) ? INIT_MIN : v;
    end
  endfunction
  lsd_dcnt #(.W(CW)) u_tmr (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .load(tmr_load),
    .value(tmr_val),
    .run(1'b1),
    .zero(tmr_zero)
  );
  // ****************************************
  // Deskew bookkeeping
  // ****************************************
  reg [UW-1:0] ui_cnt;
  reg deskewed;
  reg periodic;
  wire need_deskew = HIGH_RATE && !deskewed;
  wire ds_ok = DESKEW_REQ && (!DESKEW_PERIODIC || !HS_BURST_ACTIVE);
  assign DESKEW_BUSY = (state == S_SYNC) || (state == S_PAY);
  // ****************************************
  // Lane state machine
  // ****************************************
  always @* begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_val = clamp_init(INIT_CYC);
    case (state)
      S_IDLE: begin
        // Master waits for protocol request; slave ignores lines until stop seen
        if (IS_MASTER ? INIT_REQ : (rx_lp == `LSD_LP11)) begin
          next_state = S_INIT;
          tmr_load = 1'b1;
        end
      end
      S_INIT: begin
        if (!IS_MASTER && rx_lp != `LSD_LP11) begin
          next_state = S_IDLE;
        end else if (tmr_zero) begin
          next_state = S_STOP;
        end
      end
      S_STOP: begin
        if (IS_MASTER && SLEEP_REQ) begin
          next_state = S_REQ;
        end else if (IS_MASTER && ds_ok && (need_deskew || DESKEW_PERIODIC)) begin
          next_state = S_SYNC;
        end else if (!IS_MASTER && rx_lp == `LSD_LP10) begin
          next_state = S_REQ;
        end
      end
      S_REQ: begin
        if (IS_MASTER) begin
          next_state = S_SLEEP;
        end else if (rx_lp == `LSD_LP00) begin
          next_state = S_SLEEP;
        end else if (rx_lp == `LSD_LP11) begin
          next_state = S_STOP;
        end else if (rx_lp == `LSD_LP01) begin
          next_state = S_RXWAIT;
        end
      end
      S_RXWAIT: begin
        if (rx_lp == `LSD_LP11) next_state = S_STOP;
      end
      S_SLEEP: begin
        if (IS_MASTER ? WAKE_REQ : (rx_lp == `LSD_LP10)) begin
          next_state = S_WAKE;
          tmr_load = 1'b1;
          tmr_val = WAKE_CYC;
        end
      end
      S_WAKE: begin
        if (IS_MASTER ? tmr_zero : (rx_lp == `LSD_LP11)) begin
          next_state = S_STOP;
        end
      end
      S_SYNC: begin
        if (hs_edge && ui_cnt == `LSD_SYNC_UI - 1) next_state = S_PAY;
      end
      S_PAY: begin
        if (hs_edge && ui_cnt == (periodic ? `LSD_PER_PAY_UI - 1 : `LSD_INIT_PAY_UI - 1)) begin
          next_state = S_STOP;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state <= S_IDLE;
      ui_cnt <= {UW{1'b0}};
      deskewed <= 1'b0;
      periodic <= 1'b0;
      INIT_DONE <= 1'b0;
      RX_ABORT <= 1'b0;
    end else begin
      state <= next_state;
      if (state == S_INIT && next_state == S_STOP) INIT_DONE <= 1'b1;
      RX_ABORT <= !IS_MASTER && state == S_REQ && next_state != S_SLEEP && next_state != S_REQ;
      if (RATE_CHANGED) deskewed <= 1'b0;
      else if (state == S_PAY && next_state == S_STOP && !periodic) deskewed <= 1'b1;
      if (state == S_STOP && next_state == S_SYNC) periodic <= !need_deskew;
      if (next_state != state) ui_cnt <= {UW{1'b0}};
      else if (hs_edge) ui_cnt <= ui_cnt + {{(UW-1){1'b0}}, 1'b1};
    end
  end
  // ****************************************
  // Line drive and flags
  // ****************************************
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      TX_LP_OE <= 1'b0;
      TX_LP <= `LSD_LP00;
      RX_SLEEP <= 1'b0;
      LOW_POWER <= 1'b0;
      HS_EN <= 1'b0;
      HS_SERIAL <= {LANES{1'b0}};
    end else begin
      TX_LP_OE <= IS_MASTER && next_state != S_IDLE && !(next_state == S_SYNC || next_state == S_PAY);
      case (next_state)
        S_REQ: TX_LP <= `LSD_LP10;
        S_SLEEP: TX_LP <= `LSD_LP00;
        S_WAKE: TX_LP <= `LSD_LP10;
        default: TX_LP <= `LSD_LP11;
      endcase
      RX_SLEEP <= !IS_MASTER && next_state == S_SLEEP;
      LOW_POWER <= next_state == S_SLEEP;
      HS_EN <= IS_MASTER && (next_state == S_SYNC || next_state == S_PAY);
      // All lanes carry the same pattern in the same cycle
      if (next_state == S_SYNC) HS_SERIAL <= {LANES{1'b1}};
      else if (next_state == S_PAY) HS_SERIAL <= {LANES{ui_cnt[0]}};
      else HS_SERIAL <= {LANES{1'b0}};
    end
  end
  // ****************************************
  // Receiver calibration and clock absence
  // ****************************************
  reg [4:0] ones;
  reg rx_cal_per;
  reg [CW-1:0] cal_cnt;
  reg [CW-1:0] miss_cnt;
  wire all_one = &rx_hs;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ones <= 5'h00;
      RX_CAL_ACTIVE <= 1'b0;
      RX_CAL_TIMEOUT <= 1'b0;
      rx_cal_per <= 1'b0;
      cal_cnt <= {CW{1'b0}};
      miss_cnt <= {CW{1'b0}};
      CHECK_REINIT <= 1'b0;
    end else begin
      if (hs_edge) ones <= all_one ? ((ones == 5'h1f) ? ones : ones + 5'h01) : 5'h00;
      RX_CAL_TIMEOUT <= 1'b0;
      if (!IS_MASTER && !RX_CAL_ACTIVE && hs_edge && all_one && ones == `LSD_SYNC_UI - 1) begin
        RX_CAL_ACTIVE <= 1'b1;
        rx_cal_per <= deskewed;
        cal_cnt <= deskewed ? CAL_PER_CYC : CAL_INIT_CYC;
      end else if (RX_CAL_ACTIVE) begin
        if (cal_cnt == {CW{1'b0}}) begin
          RX_CAL_ACTIVE <= 1'b0;
          RX_CAL_TIMEOUT <= 1'b1;
        end else begin
          cal_cnt <= cal_cnt - {{(CW-1){1'b0}}, 1'b1};
        end
      end
      if (hs_edge) miss_cnt <= MISS_CYC;
      else if (miss_cnt != {CW{1'b0}}) miss_cnt <= miss_cnt - {{(CW-1){1'b0}}, 1'b1};
      CHECK_REINIT <= TEST_MODE && !hs_edge && miss_cnt == {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // lsd_lane_ctrl

/* File: dv/lsd_lane_ctrl_props.sv */
// Checker for the lane controller top ports
`timescale 1ns/1ps
`include "lsd_regs.vh"
module lsd_lane_ctrl_props (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic IS_MASTER,
  input wire logic HIGH_RATE,
  input wire logic HS_BURST_ACTIVE,
  input wire logic INIT_DONE,
  input wire logic TX_LP_OE,
  input wire logic [1:0] TX_LP,
  input wire logic RX_SLEEP,
  input wire logic RX_ABORT,
  input wire logic LOW_POWER,
  input wire logic CHECK_REINIT,
  input wire logic DESKEW_BUSY,
  input wire logic RX_CAL_ACTIVE,
  input wire logic RX_CAL_TIMEOUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_reset_clears: assert property ($rose(RST_N) |-> !INIT_DONE && !TX_LP_OE && !LOW_POWER)
    else $error("outputs not cleared by reset");
  a_done_sticky: assert property (INIT_DONE |=> INIT_DONE)
    else $error("init done dropped");
  a_abort_pulse: assert property (RX_ABORT |=> !RX_ABORT)
    else $error("abort longer than one cycle");
  a_abort_no_sleep: assert property (RX_ABORT |-> !RX_SLEEP)
    else $error("sleep flagged on abort");
  a_reinit_pulse: assert property (CHECK_REINIT |=> !CHECK_REINIT)
    else $error("checker reinit longer than one cycle");
  a_cal_end_pulse: assert property (RX_CAL_TIMEOUT |=> !RX_CAL_TIMEOUT && !RX_CAL_ACTIVE)
    else $error("calibration window end wrong");
  a_sleep_all_low: assert property (IS_MASTER && $rose(LOW_POWER) |-> TX_LP_OE && TX_LP == `LSD_LP00)
    else $error("sleep without all-low lines");
  a_no_early_sleep: assert property (IS_MASTER && !INIT_DONE |-> !LOW_POWER && !DESKEW_BUSY)
    else $error("activity before init");
  a_periodic_wait: assert property ($rose(DESKEW_BUSY) && !HIGH_RATE |-> !$past(HS_BURST_ACTIVE))
    else $error("deskew started during burst");
  c_init: cover property ($rose(INIT_DONE));
  c_sleep: cover property ($rose(RX_SLEEP));
  c_deskew: cover property ($rose(DESKEW_BUSY));
  c_abort: cover property (RX_ABORT);
endmodule // lsd_lane_ctrl_props
bind lsd_lane_ctrl lsd_lane_ctrl_props u_props (.*);

/* File: dv/lsd_peer.sv */
// Peer lane model: low-power lines, unit-interval clock and high-speed bits
`timescale 1ns/1ps
module lsd_peer #(
  parameter LANES = 2
) (
  input wire logic clk,
  output logic [1:0] lp,
  output logic ui_clk,
  output logic [LANES-1:0] hs
);
  initial begin
    lp = 2'h3;
    ui_clk = 1'b0;
    hs = {LANES{1'b0}};
  end
  task automatic line(input logic [1:0] s, input int n);
    @(posedge clk);
    lp <= s;
    repeat (n) @(posedge clk);
  endtask
  // Link clock toggles n times, 100 ns per half period, with the high-speed bits left unchanged
  task automatic run_clk(input int n);
    repeat (n) #100 ui_clk = ~ui_clk;
  endtask
  task automatic burst(input int n);
    for (int i = 0; i < n + 16; i++) begin
      hs = (i < 16) ? {LANES{1'b1}} : {LANES{i[0]}};
      #50 ui_clk = ~ui_clk;
      #50;
    end
    hs = ~hs;
  endtask
endmodule // lsd_peer

/* File: dv/lsd_lane_ctrl_tb_top.sv */
// Testbench for the lane sleep, initialization and deskew controller
`timescale 1ns/1ps
`include "lsd_regs.vh"
module lsd_lane_ctrl_tb_top;
  logic CLK_SYS, RST_N, IS_MASTER, INIT_REQ, SLEEP_REQ, WAKE_REQ, TEST_MODE, HIGH_RATE, RATE_CHANGED;
  logic DESKEW_REQ, DESKEW_PERIODIC, HS_BURST_ACTIVE, INIT_DONE, TX_LP_OE, RX_SLEEP, RX_ABORT, LOW_POWER;
  logic CHECK_REINIT, DESKEW_BUSY, HS_EN, RX_CAL_ACTIVE, RX_CAL_TIMEOUT, HS_BYTE_CLK;
  logic [23:0] INIT_CYC, WAKE_CYC, MISS_CYC;
  logic [1:0] TX_LP, RX_LP, HS_SERIAL, RX_HS;
  int n_errors = 0;
  int check_count = 0;
  int k;
  lsd_lane_ctrl #(.CAL_INIT_CYC(24'h00_0190), .CAL_PER_CYC(24'h00_0064)) u_dut (.*);
  lsd_peer u_peer (.clk(CLK_SYS), .lp(RX_LP), .ui_clk(HS_BYTE_CLK), .hs(RX_HS));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset(input logic m);
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    IS_MASTER <= m;
    INIT_REQ <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1'b1;
  endtask
  task automatic t_master_init;
    INIT_CYC <= 24'h00_000a;
    INIT_REQ <= 1'b1;
    for (k = 0; k < 5000 && INIT_DONE !== 1'b1; k++) @(negedge CLK_SYS);
    chk(INIT_DONE, 1);
    chk(k >= 3995 && k <= 4010, 1);
    chk({TX_LP_OE, TX_LP}, 3'h7);
  endtask
  task automatic t_master_sleep;
    @(posedge CLK_SYS);
    SLEEP_REQ <= 1'b1;
    for (k = 0; k < 20 && TX_LP !== `LSD_LP10; k++) @(negedge CLK_SYS);
    chk(TX_LP, `LSD_LP10);
    @(negedge CLK_SYS);
    chk(TX_LP, `LSD_LP00);
    for (k = 0; k < 10 && LOW_POWER !== 1'b1; k++) @(negedge CLK_SYS);
    chk(LOW_POWER, 1);
    @(posedge CLK_SYS);
    SLEEP_REQ <= 1'b0;
    WAKE_CYC <= 24'h00_0014;
    WAKE_REQ <= 1'b1;
    for (k = 0; k < 20 && TX_LP !== `LSD_LP10; k++) @(negedge CLK_SYS);
    for (k = 0; k < 100 && TX_LP === `LSD_LP10; k++) @(negedge CLK_SYS);
    chk(k, 21);
    chk(TX_LP, `LSD_LP11);
    WAKE_REQ <= 1'b0;
  endtask
  task automatic t_master_deskew;
    HS_BURST_ACTIVE <= 1'b1;
    DESKEW_PERIODIC <= 1'b1;
    DESKEW_REQ <= 1'b1;
    fork
      u_peer.run_clk(2200);
      begin
        repeat (40) @(posedge CLK_SYS);
        chk(DESKEW_BUSY, 0);
        HS_BURST_ACTIVE <= 1'b0;
        for (k = 0; k < 100 && DESKEW_BUSY !== 1'b1; k++) @(negedge CLK_SYS);
        chk(DESKEW_BUSY, 1);
        @(negedge CLK_SYS);
        chk(HS_EN, 1);
        DESKEW_REQ <= 1'b0;
        for (k = 0; k < 40 && HS_SERIAL !== 2'h3; k++) @(negedge CLK_SYS);
        chk(HS_SERIAL, 2'h3);
        for (k = 0; k < 6000 && DESKEW_BUSY === 1'b1; k++) @(negedge CLK_SYS);
        chk(k >= 4050 && k <= 4300, 1);
      end
    join
  endtask
  task automatic t_slave;
    INIT_CYC <= 24'h00_000a;
    u_peer.line(`LSD_LP00, 50);
    u_peer.line(`LSD_LP11, 4100);
    chk(INIT_DONE, 1);
    u_peer.line(`LSD_LP10, 3);
    u_peer.line(`LSD_LP00, 10);
    chk({RX_SLEEP, LOW_POWER}, 2'h3);
    u_peer.line(`LSD_LP10, 20);
    u_peer.line(`LSD_LP11, 10);
    chk(RX_SLEEP, 0);
    u_peer.line(`LSD_LP10, 3);
    u_peer.line(`LSD_LP11, 0);
    for (k = 0; k < 10 && RX_ABORT !== 1'b1; k++) @(negedge CLK_SYS);
    chk(RX_ABORT, 1);
    u_peer.line(`LSD_LP10, 3);
    u_peer.line(`LSD_LP01, 10);
    chk(RX_SLEEP, 0);
    u_peer.line(`LSD_LP11, 10);
  endtask
  task automatic t_slave_cal;
    @(posedge CLK_SYS);
    MISS_CYC <= 24'h00_0032;
    TEST_MODE <= 1'b1;
    fork
      u_peer.burst(1024);
      begin
        for (k = 0; k < 300 && RX_CAL_ACTIVE !== 1'b1; k++) @(negedge CLK_SYS);
        chk(RX_CAL_ACTIVE, 1);
        for (k = 0; k < 500 && RX_CAL_TIMEOUT !== 1'b1; k++) @(negedge CLK_SYS);
        chk(k >= 380 && k <= 410, 1);
      end
    join
    for (k = 0; k < 200 && CHECK_REINIT !== 1'b1; k++) @(negedge CLK_SYS);
    chk(CHECK_REINIT, 1);
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    #2_000_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    RST_N = 1'b0;
    {SLEEP_REQ, WAKE_REQ, TEST_MODE, HIGH_RATE, RATE_CHANGED} = 5'h00;
    {DESKEW_REQ, DESKEW_PERIODIC, HS_BURST_ACTIVE} = 3'h0;
    {INIT_CYC, WAKE_CYC, MISS_CYC} = 72'h0;
    do_reset(1'b1);
    t_master_init();
    t_master_sleep();
    t_master_deskew();
    do_reset(1'b0);
    t_slave();
    t_slave_cal();
    end_of_test();
  end
endmodule // lsd_lane_ctrl_tb_top
